// ==== design/sfrp_fifo.sv ====
// Stream FIFO with AXI4-Stream read port, thresholds, ECC and APB status
`timescale 1ns/1ps

// Notes on behaviour
// - A word leaves the output only in a cycle where valid and ready are both high.
// - The payload bus is a whole number of bytes, taken from the stored word.
// - The strobe bus has one bit per byte, bit 0 for the lowest byte; set means data.
// - The keep bus has one bit per byte; a clear bit marks a null byte.
// - Last is raised on the word that ends a packet, keeping packet boundaries.
// - The stream identifier of each word is shown on the identifier field.
// - Destination and user bits travel with each word and are shown with it.
// - The full threshold sets where the full flag toggles and is loaded at the first edge after reset release.
// - The empty threshold sets where the empty flag toggles and is loaded at the first edge after reset release.
// - With ECC built in, injection corrupts one bit of the stored word for correction.
// - The full flag is high while the count is at or above its threshold.
// - The empty flag is high while the count is at or below its threshold.
module sfrp_fifo
	import sfrp_pkg::*;
#(
	parameter int DATA_W = 64,
	parameter int ID_W   = 4,
	parameter int DEST_W = 4,
	parameter int USER_W = 4,
	parameter int DEPTH  = 512,
	parameter bit ECC_EN = 1'b1,
	parameter int TH_W   = $clog2(DEPTH)
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              s_axis_tvalid,
	output logic                   s_axis_tready,
	input  wire logic [DATA_W-1:0] s_axis_tdata,
	input  wire logic [DATA_W/8-1:0] s_axis_tstrb,
	input  wire logic [DATA_W/8-1:0] s_axis_tkeep,
	input  wire logic              s_axis_tlast,
	input  wire logic [ID_W-1:0]   s_axis_tid,
	input  wire logic [DEST_W-1:0] s_axis_tdest,
	input  wire logic [USER_W-1:0] s_axis_tuser,
	output logic                   m_axis_tvalid,
	input  wire logic              m_axis_tready,
	output logic [DATA_W-1:0]      m_axis_tdata,
	output logic [DATA_W/8-1:0]    m_axis_tstrb,
	output logic [DATA_W/8-1:0]    m_axis_tkeep,
	output logic                   m_axis_tlast,
	output logic [ID_W-1:0]        m_axis_tid,
	output logic [DEST_W-1:0]      m_axis_tdest,
	output logic [USER_W-1:0]      m_axis_tuser,
	input  wire logic [TH_W-1:0]   axis_prog_full_thresh,
	input  wire logic [TH_W-1:0]   axis_prog_empty_thresh,
	input  wire logic              axis_injectsbiterr,
	output logic                   axis_prog_full,
	output logic                   axis_prog_empty
);

	localparam int SW = DATA_W / 8;
	localparam int PW = DATA_W + 2 * SW + 1 + ID_W + DEST_W + USER_W;
	localparam int CL = $clog2(PW + 2);
	localparam int CB = CL + 1;
	localparam int MW = PW + CB;
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 2;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_C   = CW'(1);

	// Parameter sets that the logic cannot serve stop elaboration
	if (DATA_W < 8 || DATA_W % 8 != 0) begin : g_bad_data
		$error("DATA_W must be a whole number of bytes");
	end
	if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two of at least 4");
	end
	if (TH_W != AW || TH_W > 16) begin : g_bad_thresh
		$error("TH_W must equal log2(DEPTH) and fit 16 bits");
	end
	if (ID_W < 1 || DEST_W < 1 || USER_W < 1) begin : g_bad_side
		$error("Sideband widths must be at least one bit");
	end

	// Check column of payload bit i: top bit set, low part i+1, so
	// every column is distinct and never equals a unit vector.
	function automatic logic [CB-1:0] ecc_col(input int i);
		return {1'b1, CL'(i + 1)};
	endfunction : ecc_col

	function automatic logic [CB-1:0] ecc_enc(input logic [PW-1:0] d);
		logic [CB-1:0] c;
		c = '0;
		for (int i = 0; i < PW; i++) begin
			if (d[i]) begin
				c = c ^ ecc_col(i);
			end
		end
		return c;
	endfunction : ecc_enc

	// Control and status state
	logic [1:0]          ctrl_q, ctrl_d;
	logic [15:0]         ecc_cnt_q, ecc_cnt_d;
	logic [TH_W-1:0]     pf_thr_q, pf_thr_d;
	logic [TH_W-1:0]     pe_thr_q, pe_thr_d;
	logic                thr_ld_q, thr_ld_d;
	sfrp_apb_state_t     apb_q, apb_d;
	logic [31:0]         prdata_q, prdata_d;
	logic                pready_q, pready_d;
	logic                pslverr_q, pslverr_d;

	// FIFO state
	logic [AW-1:0]       wptr_q, wptr_d;
	logic [AW-1:0]       rptr_q, rptr_d;
	logic [CW-1:0]       cnt_q, cnt_d;
	logic                fly_q, fly_d;
	logic                ov_q, ov_d;
	logic                in_rdy_q, in_rdy_d;
	logic                pf_q, pf_d;
	logic                pe_q, pe_d;
	logic [PW-1:0]       out_q, out_d;

	logic                push;
	logic                pop;
	logic                issue;
	logic [CW-1:0]       total_d;
	logic [PW-1:0]       wr_pay;
	logic [MW-1:0]       wr_word;
	logic [MW-1:0]       rd_word;
	logic [PW-1:0]       fix_pay;
	logic                fix_hit;
	logic                apb_xfer;

	assign push = s_axis_tvalid && in_rdy_q;
	assign pop  = ov_q && m_axis_tready;

	// One read in flight or parked at a time; steady throughput is
	// one word per two cycles, traded for a very small read path.
	assign issue = (cnt_q != '0) && !ctrl_q[SFRP_CTRL_PAUSE_BIT] &&
		!fly_q && (!ov_q || pop);

	// Field order inside a stored word, kept identical on the way out
	assign wr_pay = {s_axis_tuser, s_axis_tdest, s_axis_tid,
		s_axis_tlast, s_axis_tkeep, s_axis_tstrb, s_axis_tdata};

	always_comb begin
		logic [CB-1:0] chk;
		logic [PW-1:0] pay;
		chk = '0;
		pay = wr_pay;
		if (ECC_EN) begin
			chk = ecc_enc(wr_pay);
			if (axis_injectsbiterr || ctrl_q[SFRP_CTRL_INJECT_BIT]) begin
				pay[0] = ~pay[0];
			end
		end
		wr_word = {chk, pay};
	end

	sfrp_mem #(
		.W     (MW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk     (pclk),
		.rst_n   (presetn),
		.we      (push),
		.waddr   (wptr_q),
		.wdata   (wr_word),
		.re      (issue),
		.raddr   (rptr_q),
		.rdata_q (rd_word)
	);

	// Single-bit correction on the word leaving the store
	always_comb begin
		logic [CB-1:0] syn;
		syn = '0;
		fix_pay = rd_word[PW-1:0];
		fix_hit = 1'b0;
		if (ECC_EN) begin
			syn = rd_word[MW-1:PW] ^ ecc_enc(rd_word[PW-1:0]);
			fix_hit = (syn != '0);
			for (int i = 0; i < PW; i++) begin
				if (syn == ecc_col(i)) begin
					fix_pay[i] = ~fix_pay[i];
				end
			end
		end
	end

	always_comb begin
		wptr_d   = push ? wptr_q + 1'b1 : wptr_q;
		rptr_d   = issue ? rptr_q + 1'b1 : rptr_q;
		cnt_d    = cnt_q + (push ? ONE_C : '0) - (issue ? ONE_C : '0);
		fly_d    = issue;
		out_d    = fly_q ? fix_pay : out_q;
		ov_d     = ov_q;
		if (fly_q) begin
			ov_d = 1'b1;
		end else if (pop) begin
			ov_d = 1'b0;
		end
		in_rdy_d = cnt_d < DEPTH_C;
		total_d  = cnt_d + (fly_d ? ONE_C : '0) + (ov_d ? ONE_C : '0);
		pf_d     = total_d >= CW'(pf_thr_q);
		pe_d     = total_d <= CW'(pe_thr_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr_q   <= '0;
			rptr_q   <= '0;
			cnt_q    <= '0;
			fly_q    <= 1'b0;
			ov_q     <= 1'b0;
			out_q    <= '0;
			in_rdy_q <= 1'b0;
			pf_q     <= 1'b0;
			pe_q     <= 1'b1;
		end else begin
			wptr_q   <= wptr_d;
			rptr_q   <= rptr_d;
			cnt_q    <= cnt_d;
			fly_q    <= fly_d;
			ov_q     <= ov_d;
			out_q    <= out_d;
			in_rdy_q <= in_rdy_d;
			pf_q     <= pf_d;
			pe_q     <= pe_d;
		end
	end

	// Thresholds are sampled at the first edge after reset release and
	// held afterwards; changing the pins later has no effect.
	always_comb begin
		thr_ld_d = 1'b1;
		pf_thr_d = thr_ld_q ? pf_thr_q : axis_prog_full_thresh;
		pe_thr_d = thr_ld_q ? pe_thr_q : axis_prog_empty_thresh;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_ld_q <= 1'b0;
			pf_thr_q <= '1;
			pe_thr_q <= '0;
		end else begin
			thr_ld_q <= thr_ld_d;
			pf_thr_q <= pf_thr_d;
			pe_thr_q <= pe_thr_d;
		end
	end

	// APB slave: pready rises one cycle into the access phase
	assign apb_xfer = psel && penable && pready_q;

	function automatic logic [31:0] sfrp_read(input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		if (a == SFRP_OFS_CTRL) begin
			r[1:0] = ctrl_q;
		end else if (a == SFRP_OFS_STATUS) begin
			r[SFRP_ST_PFULL_BIT]  = pf_q;
			r[SFRP_ST_PEMPTY_BIT] = pe_q;
			r[SFRP_ST_VALID_BIT]  = ov_q;
			r[SFRP_ST_READY_BIT]  = in_rdy_q;
			r[SFRP_ST_COUNT_LSB +: CW] = cnt_q +
				(fly_q ? ONE_C : '0) + (ov_q ? ONE_C : '0);
		end else if (a == SFRP_OFS_ECC_CNT) begin
			r[15:0] = ecc_cnt_q;
		end else if (a == SFRP_OFS_THRESH) begin
			r[TH_W-1:0] = pf_thr_q;
			r[SFRP_TH_EMPTY_LSB +: TH_W] = pe_thr_q;
		end
		return r;
	endfunction : sfrp_read

	function automatic logic sfrp_mapped(input logic [7:0] a);
		return a == SFRP_OFS_CTRL || a == SFRP_OFS_STATUS ||
			a == SFRP_OFS_ECC_CNT || a == SFRP_OFS_THRESH;
	endfunction : sfrp_mapped

	always_comb begin
		apb_d     = apb_q;
		pready_d  = 1'b0;
		prdata_d  = prdata_q;
		pslverr_d = 1'b0;
		case (apb_q)
			SFRP_APB_IDLE: begin
				if (psel && penable) begin
					pready_d  = 1'b1;
					pslverr_d = !sfrp_mapped(paddr);
					prdata_d  = pwrite ? '0 : sfrp_read(paddr);
					apb_d     = SFRP_APB_RESP;
				end
			end
			SFRP_APB_RESP: begin
				prdata_d = '0;
				apb_d    = SFRP_APB_IDLE;
			end
			default: begin
				apb_d = SFRP_APB_IDLE;
			end
		endcase
	end

	always_comb begin
		ctrl_d    = ctrl_q;
		ecc_cnt_d = ecc_cnt_q;
		if (apb_xfer && pwrite && paddr == SFRP_OFS_CTRL) begin
			ctrl_d = pwdata[1:0];
		end
		if (apb_xfer && pwrite && paddr == SFRP_OFS_ECC_CNT) begin
			ecc_cnt_d = '0;
		end
		// A correction in the clearing cycle still counts
		if (fly_q && fix_hit && ecc_cnt_d != '1) begin
			ecc_cnt_d = ecc_cnt_d + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_q     <= SFRP_APB_IDLE;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			ctrl_q    <= SFRP_CTRL_RST;
			ecc_cnt_q <= '0;
		end else begin
			apb_q     <= apb_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			ctrl_q    <= ctrl_d;
			ecc_cnt_q <= ecc_cnt_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	assign s_axis_tready   = in_rdy_q;
	assign m_axis_tvalid   = ov_q;
	assign axis_prog_full  = pf_q;
	assign axis_prog_empty = pe_q;

	// Output fields straight from the output register
	assign m_axis_tdata = out_q[DATA_W-1:0];
	assign m_axis_tstrb = out_q[DATA_W +: SW];
	assign m_axis_tkeep = out_q[DATA_W + SW +: SW];
	assign m_axis_tlast = out_q[DATA_W + 2 * SW];
	assign m_axis_tid   = out_q[DATA_W + 2 * SW + 1 +: ID_W];
	assign m_axis_tdest = out_q[DATA_W + 2 * SW + 1 + ID_W +: DEST_W];
	assign m_axis_tuser = out_q[PW - USER_W +: USER_W];

endmodule : sfrp_fifo

// ==== design/sfrp_pkg.sv ====
// Shared constants for the stream FIFO read port block
package sfrp_pkg;

	// APB register byte offsets
	localparam logic [7:0] SFRP_OFS_CTRL    = 8'h00;
	localparam logic [7:0] SFRP_OFS_STATUS  = 8'h04;
	localparam logic [7:0] SFRP_OFS_ECC_CNT = 8'h08;
	localparam logic [7:0] SFRP_OFS_THRESH  = 8'h0c;

	// Control register fields
	localparam int SFRP_CTRL_PAUSE_BIT  = 0;
	localparam int SFRP_CTRL_INJECT_BIT = 1;
	localparam logic [1:0] SFRP_CTRL_RST = 2'h0;

	// Status register fields
	localparam int SFRP_ST_PFULL_BIT  = 0;
	localparam int SFRP_ST_PEMPTY_BIT = 1;
	localparam int SFRP_ST_VALID_BIT  = 2;
	localparam int SFRP_ST_READY_BIT  = 3;
	localparam int SFRP_ST_COUNT_LSB  = 16;

	// Threshold register: full threshold low half, empty high half
	localparam int SFRP_TH_EMPTY_LSB = 16;

	// APB slave states, one-hot
	typedef enum logic [1:0] {
		SFRP_APB_IDLE = 2'b01,
		SFRP_APB_RESP = 2'b10
	} sfrp_apb_state_t;

endpackage : sfrp_pkg

// ==== design/sfrp_mem.sv ====
// Simple dual-port word store with registered read data
`timescale 1ns/1ps
module sfrp_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_q
);

	logic [W-1:0] mem [DEPTH];

	// No reset on the array so it can map onto block RAM
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else if (re) begin
			rdata_q <= mem[raddr];
		end
	end

endmodule : sfrp_mem

// ==== testbench/sfrp_fifo_properties.sv ====
// Port-level assertions for the stream FIFO read port
`timescale 1ns/1ps
module sfrp_fifo_chk #(
	parameter int DATA_W = 64,
	parameter int DEPTH  = 512,
	parameter int TH_W   = 9
) (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic                s_axis_tvalid,
	input wire logic                s_axis_tready,
	input wire logic                m_axis_tvalid,
	input wire logic                m_axis_tready,
	input wire logic [DATA_W-1:0]   m_axis_tdata,
	input wire logic [DATA_W/8-1:0] m_axis_tkeep,
	input wire logic                m_axis_tlast,
	input wire logic [TH_W-1:0]     axis_prog_full_thresh,
	input wire logic [TH_W-1:0]     axis_prog_empty_thresh,
	input wire logic                axis_prog_full,
	input wire logic                axis_prog_empty
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0]     cnt_q, cnt_d;
	logic [TH_W-1:0] fth_q, fth_d, eth_q, eth_d;
	logic            go_q, go_d;
	// Word count rebuilt from both handshakes; thresholds as first latched
	always_comb begin
		cnt_d = cnt_q + 16'(s_axis_tvalid && s_axis_tready)
			- 16'(m_axis_tvalid && m_axis_tready);
		go_d  = 1'b1;
		fth_d = go_q ? fth_q : axis_prog_full_thresh;
		eth_d = go_q ? eth_q : axis_prog_empty_thresh;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			go_q  <= 1'b0;
			fth_q <= '0;
			eth_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			go_q  <= go_d;
			fth_q <= fth_d;
			eth_q <= eth_d;
		end
	end
	property p_hold;
		m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid
			&& $stable(m_axis_tdata) && $stable(m_axis_tkeep)
			&& $stable(m_axis_tlast);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output word changed before it was taken");
	property p_valid_cnt;
		m_axis_tvalid |-> cnt_q != 16'h0;
	endproperty
	a_valid_cnt: assert property (p_valid_cnt)
		else $error("output valid with no stored word");
	property p_full;
		go_q && axis_prog_full |-> cnt_q >= fth_q || $past(cnt_q) >= fth_q;
	endproperty
	a_full: assert property (p_full)
		else $error("full flag high below threshold");
	property p_nofull;
		go_q && !axis_prog_full |-> cnt_q < fth_q || $past(cnt_q) < fth_q;
	endproperty
	a_nofull: assert property (p_nofull)
		else $error("full flag low at or above threshold");
	property p_empty;
		go_q && axis_prog_empty |-> cnt_q <= eth_q || $past(cnt_q) <= eth_q;
	endproperty
	a_empty: assert property (p_empty)
		else $error("empty flag high above threshold");
	property p_noempty;
		go_q && !axis_prog_empty |-> cnt_q > eth_q || $past(cnt_q) > eth_q;
	endproperty
	a_noempty: assert property (p_noempty)
		else $error("empty flag low at or below threshold");
	property p_cap;
		go_q && !s_axis_tready |-> cnt_q >= DEPTH && cnt_q <= DEPTH + 2;
	endproperty
	a_cap: assert property (p_cap)
		else $error("input refused while not full");
	property p_apb;
		psel && penable && !$past(penable) |-> !pready ##1 pready;
	endproperty
	a_apb: assert property (p_apb)
		else $error("access phase not two cycles");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err)
		else $error("error response without ready");
	property p_rd0;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rd0: assert property (p_rd0)
		else $error("read data outside the answer cycle");
endmodule : sfrp_fifo_chk

bind sfrp_fifo sfrp_fifo_chk #(.DATA_W(DATA_W), .DEPTH(DEPTH), .TH_W(TH_W))
	i_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
	.s_axis_tvalid, .s_axis_tready, .m_axis_tvalid, .m_axis_tready,
	.m_axis_tdata, .m_axis_tkeep, .m_axis_tlast, .axis_prog_full_thresh,
	.axis_prog_empty_thresh, .axis_prog_full, .axis_prog_empty);

// ==== testbench/sfrp_sink.sv ====
// Downstream stream receiver model
`timescale 1ns/1ps
module sfrp_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall,
	output logic     tready
);
	logic [1:0] ph_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ph_q <= 2'h0;
		else
			ph_q <= ph_q + 2'h1;
	end
	// Skips one cycle in four so the sender must hold its word
	assign tready = presetn && !stall && ph_q != 2'h3;
endmodule : sfrp_sink

// ==== testbench/tb_stream_fifo_read_port_sideband.sv ====
// Self-checking bench for the stream FIFO read port
`timescale 1ns/1ps
module tb_stream_fifo_read_port_sideband;
	import sfrp_pkg::*;
	localparam int DEPTH = 16;
	typedef struct packed {
		logic [63:0] d;
		logic [7:0]  s;
		logic [7:0]  k;
		logic        l;
		logic [3:0]  i;
		logic [3:0]  t;
		logic [3:0]  u;
	} sfrp_beat_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        er, s_axis_tvalid, s_axis_tready, m_axis_tvalid, tready;
	logic        axis_injectsbiterr, axis_prog_full, axis_prog_empty;
	logic [3:0]  axis_prog_full_thresh, axis_prog_empty_thresh;
	sfrp_beat_t  in_b, exp_q[$];
	wire sfrp_beat_t mo;
	int          miscompares, total_checks;
	sfrp_beat_t  rows [4] = '{
		'{64'h0123456789abcdef, 8'hff, 8'hff, 1'b0, 4'h1, 4'h2, 4'h3},
		'{64'hfedcba9876543210, 8'h01, 8'h0f, 1'b1, 4'h1, 4'h5, 4'ha},
		'{64'h00000000000000ff, 8'h80, 8'h00, 1'b0, 4'hf, 4'h0, 4'hf},
		'{64'h8000000000000001, 8'h7e, 8'hf0, 1'b1, 4'h0, 4'hf, 4'h0}};
	sfrp_fifo #(.DATA_W(64), .ID_W(4), .DEST_W(4), .USER_W(4), .DEPTH(DEPTH),
		.ECC_EN(1'b1)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .s_axis_tvalid,
		.s_axis_tready, .s_axis_tdata(in_b.d), .s_axis_tstrb(in_b.s),
		.s_axis_tkeep(in_b.k), .s_axis_tlast(in_b.l), .s_axis_tid(in_b.i),
		.s_axis_tdest(in_b.t), .s_axis_tuser(in_b.u), .m_axis_tvalid,
		.m_axis_tready(tready), .m_axis_tdata(mo.d), .m_axis_tstrb(mo.s),
		.m_axis_tkeep(mo.k), .m_axis_tlast(mo.l), .m_axis_tid(mo.i),
		.m_axis_tdest(mo.t), .m_axis_tuser(mo.u), .axis_prog_full_thresh,
		.axis_prog_empty_thresh, .axis_injectsbiterr, .axis_prog_full,
		.axis_prog_empty);
	sfrp_sink i_sink (.pclk, .presetn, .stall, .tready);
	always #4 pclk = ~pclk;
	task automatic check(input string nm, input logic [95:0] seen,
		input logic [95:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic fail_to;
		miscompares++;
		print_verdict();
	endtask : fail_to
	// Holds valid up on exit so back-to-back pushes stay gapless
	task automatic push(input sfrp_beat_t b);
		int n = 0;
		s_axis_tvalid <= 1'b1;
		in_b <= b;
		do begin
			@(posedge pclk);
			n++;
		end while (s_axis_tready !== 1'b1 && n < 2000);
		exp_q.push_back(b);
		if (n >= 2000)
			fail_to();
	endtask : push
	task automatic drain;
		int n = 0;
		s_axis_tvalid <= 1'b0;
		axis_injectsbiterr <= 1'b0;
		while (exp_q.size() != 0 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		if (n >= 2000)
			fail_to();
	endtask : drain
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 100)
			fail_to();
	endtask : apb
	always @(posedge pclk) begin
		if (presetn && m_axis_tvalid === 1'b1 && tready === 1'b1)
			check("word", mo, exp_q.size() ? exp_q.pop_front() :
				sfrp_beat_t'('1));
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{s_axis_tvalid, axis_injectsbiterr, stall} = '0;
		in_b = '0;
		axis_prog_full_thresh = 4'h6;
		axis_prog_empty_thresh = 4'h2;
		repeat (12) @(posedge pclk);
		check("rst_valid", m_axis_tvalid, 1'b0);
		check("rst_pempty", axis_prog_empty, 1'b1);
		check("rst_pfull", axis_prog_full, 1'b0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		foreach (rows[r])
			push(rows[r]);
		drain();
		axis_injectsbiterr <= 1'b1;
		push(rows[1]);
		drain();
		apb(1'b0, SFRP_OFS_ECC_CNT, 32'h0);
		check("ecc_cnt", rd, 32'h1);
		apb(1'b1, SFRP_OFS_ECC_CNT, 32'h0);
		apb(1'b0, SFRP_OFS_ECC_CNT, 32'h0);
		check("ecc_clr", rd, 32'h0);
		// Pause holds the word in store; inject through the control bit
		apb(1'b1, SFRP_OFS_CTRL, 32'h3);
		push(rows[0]);
		s_axis_tvalid <= 1'b0;
		apb(1'b0, SFRP_OFS_STATUS, 32'h0);
		check("paused", m_axis_tvalid, 1'b0);
		check("status", rd, (32'h1 << SFRP_ST_COUNT_LSB) |
			(32'h1 << SFRP_ST_PEMPTY_BIT) | (32'h1 << SFRP_ST_READY_BIT));
		apb(1'b1, SFRP_OFS_CTRL, 32'h0);
		drain();
		apb(1'b0, SFRP_OFS_ECC_CNT, 32'h0);
		check("ecc_ctrl", rd, 32'h1);
		apb(1'b0, SFRP_OFS_THRESH, 32'h0);
		check("thresh", rd, 32'h6 | (32'h2 << SFRP_TH_EMPTY_LSB));
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", {er, rd}, 33'h100000000);
		stall <= 1'b1;
		// Store plus output register hold DEPTH + 1 words while stalled
		for (int i = 0; i < DEPTH + 1; i++)
			push('{64'(i), 8'hff, 8'h0f, i[0], i[3:0], 4'h9, 4'h6});
		in_b <= rows[2];
		repeat (8) @(posedge pclk);
		check("refused", s_axis_tready, 1'b0);
		check("pfull", axis_prog_full, 1'b1);
		check("pempty_off", axis_prog_empty, 1'b0);
		stall <= 1'b0;
		push(rows[2]);
		drain();
		check("pfull_off", axis_prog_full, 1'b0);
		check("pempty", axis_prog_empty, 1'b1);
		// Mid-run reset with new thresholds presented while it is held
		presetn <= 1'b0;
		axis_prog_full_thresh <= 4'h2;
		axis_prog_empty_thresh <= 4'h1;
		repeat (2) @(posedge pclk);
		check("rst2_valid", m_axis_tvalid, 1'b0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(1'b0, SFRP_OFS_THRESH, 32'h0);
		check("thresh2", rd, 32'h2 | (32'h1 << SFRP_TH_EMPTY_LSB));
		stall <= 1'b1;
		repeat (2) push(rows[3]);
		s_axis_tvalid <= 1'b0;
		repeat (4) @(posedge pclk);
		check("pfull_new", axis_prog_full, 1'b1);
		check("pempty_new", axis_prog_empty, 1'b0);
		stall <= 1'b0;
		drain();
		print_verdict();
	end
endmodule : tb_stream_fifo_read_port_sideband
